//--- pin_function_multiplexer.sv
// Operation
// - Port B lines 2-3 supply: upper field bit 0 core, 1 auxiliary; lower ignored.
// - Port A lines 6-7 supply: pattern 0x core, 1x auxiliary.
// - Group uses auxiliary supply only if port F line 0 selects it and field is 1x.
// - Port B low select bits 1:0 unimplemented, read zero.
// - PA3: 00 I/O+capture, 01 timer out, 10 SPI data out, 11 oscillator.
// - PA2: 00/01/10 I/O with timer clock, 11 crystal pin two.
// - PA1: 00 I/O+irq, 01 op-amp, 10 voltage detect, 11 inverted timer out.
// - PA0: 00/01 I/O+capture, 10 timer out, 11 crystal pin one.
// - PA7 and PA6 fields select serial, UART, SPI or I/O as listed.
// - PA5 and PA4 fields select timer, SPI, op-amp, oscillator or I/O.
// - PB3 and PB2 fields select serial, SPI, UART, segment or I/O.
// - PB1: 00/01 I/O+irq, 10 inverted timer out, 11 segment.
// - PB7..PB4: code 01 segment, otherwise plain I/O.
// - PC3, PC1, PC7, PC6: code 01 segment, otherwise I/O.
// - PC2 and PC0 fields select timer out, segment or I/O.
// - PC5 and PC4 fields select UART, serial, SPI or I/O.
// - PD3..PD0: 01 segment, 10 common, otherwise I/O.
// - PD7: code 01 segment, otherwise I/O.
// - PD6: 01 segment, 10 bias; resistor-type control forces bias.
// - PD5: 01 segment, 10 pump capacitor, otherwise I/O; resistor-type control forces pump on any code.
// - Direction bit 0 output, 1 input; resets to input.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module pin_function_multiplexer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register bus write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Register bus read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Pin function per line, five bits per line, line 0 lowest
    output logic [39:0] pin_func_a,
    output logic [39:0] pin_func_b,
    output logic [39:0] pin_func_c,
    output logic [39:0] pin_func_d,
    // General I/O output drivers
    output logic [7:0] pin_out_en_a,
    output logic [7:0] pin_out_en_b,
    output logic [7:0] pin_out_en_c,
    output logic [7:0] pin_out_en_d,
    // Multi-power groups: 0 port A 6-7, 1 port B 2-3, 2 port C 4-5
    output logic [2:0] aux_supply_sel
);

    typedef struct packed {
        logic [9:0][7:0] sel;
        logic [3:0][7:0] dir;
        logic lcd_resistor_type_ctrl;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0][7:0][4:0] func;
        logic [3:0][7:0] oe;
        logic [2:0] aux;
    } state_type;

    state_type st_reg;
    state_type st_next;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [4:0] pick4(input logic [1:0] code, input logic [4:0] f0,
                                         input logic [4:0] f1, input logic [4:0] f2,
                                         input logic [4:0] f3);
        logic [4:0] r;
        unique case (code)
            2'b00: r = f0;
            2'b01: r = f1;
            2'b10: r = f2;
            2'b11: r = f3;
        endcase
        return r;
    endfunction

    function automatic logic [4:0] pin_func(input logic [1:0] port, input logic [2:0] line,
                                            input logic [1:0] c, input logic force_lcd);
        logic [4:0] r;
        r = pin_mux_pkg::FN_GPIO;
        unique case ({port, line})
            5'd0: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT,
                            pin_mux_pkg::FN_XTAL);
            5'd1: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_OPAMP, pin_mux_pkg::FN_LVD,
                            pin_mux_pkg::FN_TM_OUT_INV);
            5'd2: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO,
                            pin_mux_pkg::FN_XTAL);
            5'd3: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT, pin_mux_pkg::FN_SPI_DOUT,
                            pin_mux_pkg::FN_OSC);
            5'd4: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT, pin_mux_pkg::FN_SPI_SEL,
                            pin_mux_pkg::FN_OSC);
            5'd5: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT, pin_mux_pkg::FN_SPI_CLK,
                            pin_mux_pkg::FN_OPAMP);
            5'd6: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_SPI_DIN, pin_mux_pkg::FN_SER_CLK,
                            pin_mux_pkg::FN_GPIO);
            5'd7: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_SER_DATA, pin_mux_pkg::FN_UART,
                            pin_mux_pkg::FN_GPIO);
            5'd8: r = pin_mux_pkg::FN_GPIO;
            5'd9: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT_INV,
                            pin_mux_pkg::FN_LCD_SEGMENT);
            5'd10: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_SER_SEL, pin_mux_pkg::FN_SPI_CLK,
                             pin_mux_pkg::FN_LCD_SEGMENT);
            5'd11: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_SER_DOUT, pin_mux_pkg::FN_SPI_DIN,
                             pin_mux_pkg::FN_UART_TX);
            5'd12, 5'd13, 5'd14, 5'd15: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT,
                                                  pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO);
            5'd16: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT,
                             pin_mux_pkg::FN_LCD_SEGMENT);
            5'd17, 5'd19, 5'd22, 5'd23: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT,
                                                  pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_GPIO);
            5'd18: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_TM_OUT, pin_mux_pkg::FN_LCD_SEGMENT,
                             pin_mux_pkg::FN_GPIO);
            5'd20: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_SER_DOUT, pin_mux_pkg::FN_UART_TX,
                             pin_mux_pkg::FN_SPI_SEL);
            5'd21: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_UART, pin_mux_pkg::FN_SER_DATA,
                             pin_mux_pkg::FN_SPI_DOUT);
            // PD0 to PD3 segment or common
            5'd24, 5'd25, 5'd26, 5'd27: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT,
                                                  pin_mux_pkg::FN_LCD_COMMON, pin_mux_pkg::FN_GPIO);
            // PD4 and PD5 pump capacitor, forced by resistor type
            5'd28, 5'd29: r = force_lcd ? pin_mux_pkg::FN_LCD_PUMP :
                                pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT,
                                      pin_mux_pkg::FN_LCD_PUMP, pin_mux_pkg::FN_GPIO);
            // PD6 bias, forced by resistor type
            5'd30: r = force_lcd ? pin_mux_pkg::FN_LCD_BIAS :
                         pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT,
                               pin_mux_pkg::FN_LCD_BIAS, pin_mux_pkg::FN_GPIO);
            5'd31: r = pick4(c, pin_mux_pkg::FN_GPIO, pin_mux_pkg::FN_LCD_SEGMENT, pin_mux_pkg::FN_GPIO,
                             pin_mux_pkg::FN_GPIO);
        endcase
        return r;
    endfunction

    // Register index 0..15 for a mapped offset, bit 4 set when unmapped
    function automatic logic [4:0] reg_index(input logic [7:0] addr);
        return (addr[1:0] == 2'b00 && addr <= pin_mux_pkg::OFS_STATUS) ? {1'b0, addr[5:2]} : 5'h10;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [4:0] widx;
        logic [4:0] ridx;
        logic [7:0] wbyte;
        logic [1:0] code;
        st_next = st_reg;
        widx = reg_index(awaddr);
        ridx = reg_index(araddr);
        wbyte = wdata[7:0];
        code = 2'b00;
        st_next.awready = 1'b0;
        st_next.wready = 1'b0;
        st_next.arready = 1'b0;

        // Write: take address and data together, answer one cycle later
        if (awvalid && wvalid && !st_reg.awready && !st_reg.bvalid) begin
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        if (st_reg.awready) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = widx[4] ? pin_mux_pkg::RESP_SLVERR : pin_mux_pkg::RESP_OKAY;
            if (!widx[4] && wstrb[0]) begin
                if (widx[3:0] == 4'd0) begin
                    st_next.sel[0] = wbyte & pin_mux_pkg::SUPPLY_MASK;
                end else if (widx[3:0] == 4'd3) begin
                    // low bits of port B low select kept at zero
                    st_next.sel[3] = wbyte & pin_mux_pkg::PB_LO_MASK;
                end else if (widx[3:0] <= 4'd9) begin
                    st_next.sel[widx[3:0]] = wbyte;
                end else if (widx[3:0] <= 4'd13) begin
                    st_next.dir[2'(widx[3:0] - 4'd10)] = wbyte;
                end else if (widx[3:0] == 4'd14) begin
                    st_next.lcd_resistor_type_ctrl = wbyte[0];
                end
            end
        end
        if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end

        // Read: accept address, data follows one cycle later
        if (arvalid && !st_reg.arready && !st_reg.rvalid) begin
            st_next.arready = 1'b1;
        end
        if (st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = ridx[4] ? pin_mux_pkg::RESP_SLVERR : pin_mux_pkg::RESP_OKAY;
            st_next.rdata = 32'h0000_0000;
            if (!ridx[4]) begin
                if (ridx[3:0] <= 4'd9) begin
                    st_next.rdata[7:0] = st_reg.sel[ridx[3:0]];
                end else if (ridx[3:0] <= 4'd13) begin
                    st_next.rdata[7:0] = st_reg.dir[2'(ridx[3:0] - 4'd10)];
                end else if (ridx[3:0] == 4'd14) begin
                    st_next.rdata[0] = st_reg.lcd_resistor_type_ctrl;
                end else begin
                    st_next.rdata[2:0] = st_reg.aux;
                end
            end
        end
        if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end

        // Pin functions and output drivers
        for (int p = 0; p < 4; p++) begin
            for (int l = 0; l < 8; l++) begin
                code = st_reg.sel[1 + 2 * p + l / 4][2 * (l % 4) +: 2];
                st_next.func[p][l] = pin_func(2'(p), 3'(l), code, st_reg.lcd_resistor_type_ctrl);
                st_next.oe[p][l] = !st_reg.dir[p][l] && st_next.func[p][l] == pin_mux_pkg::FN_GPIO;
            end
        end

        // auxiliary supply needs port F line 0 function and upper field bit
        for (int g = 0; g < 3; g++) begin
            st_next.aux[g] = st_reg.sel[9][1:0] == pin_mux_pkg::PORTF_AUX_CODE && st_reg.sel[0][2 * g + 1];
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= '0;
            // selects come up as general I/O
            st_reg.sel <= {10{pin_mux_pkg::SEL_RESET}};
            st_reg.dir <= {4{pin_mux_pkg::DIR_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign awready = st_reg.awready;
    assign wready = st_reg.wready;
    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid = st_reg.rvalid;
    assign rresp = st_reg.rresp;
    assign rdata = st_reg.rdata;
    assign pin_func_a = st_reg.func[0];
    assign pin_func_b = st_reg.func[1];
    assign pin_func_c = st_reg.func[2];
    assign pin_func_d = st_reg.func[3];
    assign pin_out_en_a = st_reg.oe[0];
    assign pin_out_en_b = st_reg.oe[1];
    assign pin_out_en_c = st_reg.oe[2];
    assign pin_out_en_d = st_reg.oe[3];
    assign aux_supply_sel = st_reg.aux;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence portf_aux_s;
        st_reg.sel[9][1:0] == pin_mux_pkg::PORTF_AUX_CODE;
    endsequence

    sequence write_taken_s;
        awvalid && wvalid && st_reg.awready ##1 st_reg.bvalid;
    endsequence

    pb_supply_a: assert property (portf_aux_s |=> aux_supply_sel[1] == $past(st_reg.sel[0][3]))
        else $error("port B supply group wrong");
    pa_supply_a: assert property (st_reg.sel[0][1:0] == 2'b01 |=> !aux_supply_sel[0])
        else $error("port A supply taken from auxiliary on 01");
    aux_gate_a: assert property (st_reg.sel[9][1:0] != 2'b01 |=> aux_supply_sel == 3'b000)
        else $error("auxiliary supply without port F function");
    pb_low_zero_a: assert property (write_taken_s |-> st_reg.sel[3][1:0] == 2'b00)
        else $error("port B low bits not zero");
    pa3_func_a: assert property (st_reg.sel[1][7:6] == 2'b10 |=> pin_func_a[19:15] == pin_mux_pkg::FN_SPI_DOUT)
        else $error("PA3 select wrong");
    pa2_func_a: assert property (st_reg.sel[1][5:4] == 2'b10 |=> pin_func_a[14:10] == pin_mux_pkg::FN_GPIO)
        else $error("PA2 select wrong");
    pa1_func_a: assert property (st_reg.sel[1][3:2] == 2'b11 |=> pin_func_a[9:5] == pin_mux_pkg::FN_TM_OUT_INV)
        else $error("PA1 select wrong");
    pa0_func_a: assert property (st_reg.sel[1][1:0] == 2'b11 |=> pin_func_a[4:0] == pin_mux_pkg::FN_XTAL)
        else $error("PA0 select wrong");
    pa7_func_a: assert property (st_reg.sel[2][7:6] == 2'b10 |=> pin_func_a[39:35] == pin_mux_pkg::FN_UART)
        else $error("PA7 select wrong");
    pa5_func_a: assert property (st_reg.sel[2][3:2] == 2'b11 |=> pin_func_a[29:25] == pin_mux_pkg::FN_OPAMP)
        else $error("PA5 select wrong");
    pb3_func_a: assert property (st_reg.sel[3][7:6] == 2'b11 |=> pin_func_b[19:15] == pin_mux_pkg::FN_UART_TX)
        else $error("PB3 select wrong");
    pb1_func_a: assert property (st_reg.sel[3][3:2] == 2'b10 |=> pin_func_b[9:5] == pin_mux_pkg::FN_TM_OUT_INV)
        else $error("PB1 select wrong");
    pb7_func_a: assert property (st_reg.sel[4][7:6] == 2'b11 |=> pin_func_b[39:35] == pin_mux_pkg::FN_GPIO)
        else $error("PB7 select wrong");
    pc1_func_a: assert property (st_reg.sel[5][3:2] == 2'b01 |=> pin_func_c[9:5] == pin_mux_pkg::FN_LCD_SEGMENT)
        else $error("PC1 select wrong");
    pc2_func_a: assert property (st_reg.sel[5][5:4] == 2'b10
                                 |=> pin_func_c[14:10] == pin_mux_pkg::FN_LCD_SEGMENT)
        else $error("PC2 select wrong");
    pc5_func_a: assert property (st_reg.sel[6][3:2] == 2'b11 |=> pin_func_c[29:25] == pin_mux_pkg::FN_SPI_DOUT)
        else $error("PC5 select wrong");
    pd0_func_a: assert property (st_reg.sel[7][1:0] == 2'b10 |=> pin_func_d[4:0] == pin_mux_pkg::FN_LCD_COMMON)
        else $error("PD0 select wrong");
    pd7_func_a: assert property (st_reg.sel[8][7:6] == 2'b10 |=> pin_func_d[39:35] == pin_mux_pkg::FN_GPIO)
        else $error("PD7 select wrong");
    pd6_force_a: assert property (st_reg.lcd_resistor_type_ctrl
                                  |=> pin_func_d[34:30] == pin_mux_pkg::FN_LCD_BIAS)
        else $error("PD6 bias not forced");
    pd5_func_a: assert property (!st_reg.lcd_resistor_type_ctrl && st_reg.sel[8][3:2] == 2'b01
                                 |=> pin_func_d[29:25] == pin_mux_pkg::FN_LCD_SEGMENT)
        else $error("PD5 select wrong");
    dir_drive_a: assert property (st_reg.dir[0][0] |=> !pin_out_en_a[0])
        else $error("input pin driven");
    reset_sel_a: assert property ($fell(sys_rst) |-> st_reg.sel == '0 && st_reg.dir == '1)
        else $error("select or direction reset value wrong");
    pb_low_read_a: assert property (st_reg.arready && araddr == pin_mux_pkg::OFS_PB_LO |=> rdata[1:0] == 2'b00)
        else $error("port B low bits read nonzero");
    pa6_func_a: assert property (st_reg.sel[2][5:4] == 2'b01 |=> pin_func_a[34:30] == pin_mux_pkg::FN_SPI_DIN)
        else $error("PA6 select wrong");
    pa4_func_a: assert property (st_reg.sel[2][1:0] == 2'b00 |=> pin_func_a[24:20] == pin_mux_pkg::FN_GPIO)
        else $error("PA4 select wrong");
    pb2_func_a: assert property (st_reg.sel[3][5:4] == 2'b01 |=> pin_func_b[14:10] == pin_mux_pkg::FN_SER_SEL)
        else $error("PB2 select wrong");
    pb5_func_a: assert property (st_reg.sel[4][3:2] == 2'b10 |=> pin_func_b[29:25] == pin_mux_pkg::FN_GPIO)
        else $error("PB5 select wrong");
    pc0_func_a: assert property (st_reg.sel[5][1:0] == 2'b10 |=> pin_func_c[4:0] == pin_mux_pkg::FN_TM_OUT)
        else $error("PC0 select wrong");
    pc4_func_a: assert property (st_reg.sel[6][1:0] == 2'b11 |=> pin_func_c[24:20] == pin_mux_pkg::FN_SPI_SEL)
        else $error("PC4 select wrong");
    pc6_func_a: assert property (st_reg.sel[6][5:4] == 2'b01
                                 |=> pin_func_c[34:30] == pin_mux_pkg::FN_LCD_SEGMENT)
        else $error("PC6 select wrong");
    pd3_func_a: assert property (st_reg.sel[7][7:6] == 2'b01
                                 |=> pin_func_d[19:15] == pin_mux_pkg::FN_LCD_SEGMENT)
        else $error("PD3 select wrong");
    pd6_func_a: assert property (!st_reg.lcd_resistor_type_ctrl && st_reg.sel[8][5:4] == 2'b10
                                 |=> pin_func_d[34:30] == pin_mux_pkg::FN_LCD_BIAS)
        else $error("PD6 bias select wrong");
    pd5_pump_a: assert property (!st_reg.lcd_resistor_type_ctrl && st_reg.sel[8][3:2] == 2'b10
                                 |=> pin_func_d[29:25] == pin_mux_pkg::FN_LCD_PUMP)
        else $error("PD5 pump select wrong");
    pd0_drive_a: assert property (!st_reg.dir[3][0] && st_reg.sel[7][1:0] == 2'b00 |=> pin_out_en_d[0])
        else $error("output pin not driven");

endmodule

//--- pin_mux_pkg.sv
package pin_mux_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SUPPLY = 8'h00;
    localparam logic [7:0] OFS_PA_LO = 8'h04;
    localparam logic [7:0] OFS_PA_HI = 8'h08;
    localparam logic [7:0] OFS_PB_LO = 8'h0c;
    localparam logic [7:0] OFS_PB_HI = 8'h10;
    localparam logic [7:0] OFS_PC_LO = 8'h14;
    localparam logic [7:0] OFS_PC_HI = 8'h18;
    localparam logic [7:0] OFS_PD_LO = 8'h1c;
    localparam logic [7:0] OFS_PD_HI = 8'h20;
    localparam logic [7:0] OFS_PF_LO = 8'h24;
    localparam logic [7:0] OFS_DIR_A = 8'h28;
    localparam logic [7:0] OFS_DIR_B = 8'h2c;
    localparam logic [7:0] OFS_DIR_C = 8'h30;
    localparam logic [7:0] OFS_DIR_D = 8'h34;
    localparam logic [7:0] OFS_LCD_CTRL = 8'h38;
    localparam logic [7:0] OFS_STATUS = 8'h3c;

    // Writable bits, reset values and port F auxiliary code
    localparam logic [7:0] SUPPLY_MASK = 8'h3f;
    localparam logic [7:0] PB_LO_MASK = 8'hfc;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [1:0] PORTF_AUX_CODE = 2'b01;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Pin function identifiers
    localparam logic [4:0] FN_GPIO = 5'h00;
    localparam logic [4:0] FN_TM_OUT = 5'h01;
    localparam logic [4:0] FN_TM_OUT_INV = 5'h02;
    localparam logic [4:0] FN_SPI_DOUT = 5'h03;
    localparam logic [4:0] FN_SPI_DIN = 5'h04;
    localparam logic [4:0] FN_SPI_CLK = 5'h05;
    localparam logic [4:0] FN_SPI_SEL = 5'h06;
    localparam logic [4:0] FN_SER_DATA = 5'h07;
    localparam logic [4:0] FN_SER_CLK = 5'h08;
    localparam logic [4:0] FN_SER_DOUT = 5'h09;
    localparam logic [4:0] FN_SER_SEL = 5'h0a;
    localparam logic [4:0] FN_UART = 5'h0b;
    localparam logic [4:0] FN_UART_TX = 5'h0c;
    localparam logic [4:0] FN_OSC = 5'h0d;
    localparam logic [4:0] FN_XTAL = 5'h0e;
    localparam logic [4:0] FN_OPAMP = 5'h0f;
    localparam logic [4:0] FN_LVD = 5'h10;
    localparam logic [4:0] FN_LCD_SEGMENT = 5'h11;
    localparam logic [4:0] FN_LCD_COMMON = 5'h12;
    localparam logic [4:0] FN_LCD_BIAS = 5'h13;
    localparam logic [4:0] FN_LCD_PUMP = 5'h14;

endpackage

//--- pin_function_multiplexer_tb.sv
`timescale 1ns/1ps
module pin_function_multiplexer_tb;
    localparam logic [4:0] G = pin_mux_pkg::FN_GPIO, TO = pin_mux_pkg::FN_TM_OUT, TI = pin_mux_pkg::FN_TM_OUT_INV;
    localparam logic [4:0] SPO = pin_mux_pkg::FN_SPI_DOUT, SDI = pin_mux_pkg::FN_SPI_DIN;
    localparam logic [4:0] SSL = pin_mux_pkg::FN_SPI_SEL, SDA = pin_mux_pkg::FN_SER_DATA;
    localparam logic [4:0] SOU = pin_mux_pkg::FN_SER_DOUT, SSE = pin_mux_pkg::FN_SER_SEL;
    localparam logic [4:0] UA = pin_mux_pkg::FN_UART, UTX = pin_mux_pkg::FN_UART_TX, OSC = pin_mux_pkg::FN_OSC;
    localparam logic [4:0] XT = pin_mux_pkg::FN_XTAL, OP = pin_mux_pkg::FN_OPAMP, LV = pin_mux_pkg::FN_LVD;
    localparam logic [4:0] LSG = pin_mux_pkg::FN_LCD_SEGMENT, LCM = pin_mux_pkg::FN_LCD_COMMON;
    localparam logic [4:0] BIA = pin_mux_pkg::FN_LCD_BIAS, PMP = pin_mux_pkg::FN_LCD_PUMP;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp_seen;
    logic [31:0] rdata, rd_seen;
    logic [39:0] pin_func_a, pin_func_b, pin_func_c, pin_func_d;
    logic [7:0] pin_out_en_a, pin_out_en_b, pin_out_en_c, pin_out_en_d;
    logic [2:0] aux_supply_sel;
    int n_errors = 0;
    int comparisons = 0;

    always #2 core_clk = ~core_clk;

    pin_function_multiplexer DUT (
        .core_clk(core_clk), .sys_rst(sys_rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready),
        .pin_func_a(pin_func_a), .pin_func_b(pin_func_b), .pin_func_c(pin_func_c), .pin_func_d(pin_func_d),
        .pin_out_en_a(pin_out_en_a), .pin_out_en_b(pin_out_en_b), .pin_out_en_c(pin_out_en_c),
        .pin_out_en_d(pin_out_en_d), .aux_supply_sel(aux_supply_sel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Pin outputs follow one cycle after the response, so one extra edge is waited
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(posedge core_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge core_clk); while (bvalid !== 1'b1);
        resp_seen = bresp;
        bready <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        rd_seen = rdata;
        resp_seen = rresp;
        rready <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(pin_mux_pkg::OFS_PA_LO); chk("pa_lo_reset", rd_seen, 32'h0);
        rd(pin_mux_pkg::OFS_DIR_A); chk("dir_a_reset", rd_seen, 32'hff);
        chk("func_a_reset", pin_func_a, 40'h0);
        chk("func_d_reset", pin_func_d, 40'h0);
        chk("out_en_reset", pin_out_en_a, 8'h00);
        $display("test reset done");
        wr(pin_mux_pkg::OFS_PA_LO, 8'he4); chk("pa_lo_e4", pin_func_a[19:0], {OSC, G, OP, G});
        wr(pin_mux_pkg::OFS_PA_LO, 8'h1b); chk("pa_lo_1b", pin_func_a[19:0], {G, G, LV, XT});
        wr(pin_mux_pkg::OFS_PA_LO, 8'h7e); chk("pa_lo_7e", pin_func_a[19:0], {TO, XT, TI, TO});
        wr(pin_mux_pkg::OFS_PA_LO, 8'h81); chk("pa_lo_81", pin_func_a[19:0], {SPO, G, G, G});
        wr(pin_mux_pkg::OFS_PA_HI, 8'h9c); chk("pa_hi_9c", pin_func_a[39:20], {UA, SDI, OP, G});
        wr(pin_mux_pkg::OFS_DIR_A, 8'h00); chk("out_en_a", pin_out_en_a, 8'h17);
        $display("test port a done");
        wr(pin_mux_pkg::OFS_PB_LO, 8'hff); chk("pb_lo_ff", pin_func_b[19:0], {UTX, LSG, LSG, G});
        rd(pin_mux_pkg::OFS_PB_LO); chk("pb_lo_read", rd_seen, 32'hfc);
        wr(pin_mux_pkg::OFS_PB_LO, 8'h9b); chk("pb_lo_9b", pin_func_b[19:0], {SDI, SSE, TI, G});
        wr(pin_mux_pkg::OFS_PB_LO, 8'h44); chk("pb_lo_44", pin_func_b[19:0], {SOU, G, G, G});
        wr(pin_mux_pkg::OFS_PB_HI, 8'h5a); chk("pb_hi_5a", pin_func_b[39:20], {LSG, LSG, G, G});
        wr(pin_mux_pkg::OFS_DIR_B, 8'h00); chk("out_en_b", pin_out_en_b, 8'h37);
        $display("test port b done");
        wr(pin_mux_pkg::OFS_PC_LO, 8'h6e); chk("pc_lo_6e", pin_func_c[19:0], {LSG, LSG, G, TO});
        wr(pin_mux_pkg::OFS_PC_HI, 8'h1b); chk("pc_hi_1b", pin_func_c[39:20], {G, LSG, SDA, SSL});
        wr(pin_mux_pkg::OFS_DIR_C, 8'h00); chk("out_en_c", pin_out_en_c, 8'h82);
        $display("test port c done");
        wr(pin_mux_pkg::OFS_PD_LO, 8'h66); chk("pd_lo_66", pin_func_d[19:0], {LSG, LCM, LSG, LCM});
        wr(pin_mux_pkg::OFS_PD_LO, 8'hcc); chk("pd_lo_cc", pin_func_d[19:0], {G, G, G, G});
        wr(pin_mux_pkg::OFS_PD_HI, 8'h24); chk("pd_hi_24", pin_func_d[39:20], {G, BIA, LSG, G});
        wr(pin_mux_pkg::OFS_PD_HI, 8'h48); chk("pd_hi_48", pin_func_d[39:20], {LSG, G, PMP, G});
        wr(pin_mux_pkg::OFS_LCD_CTRL, 8'h01); chk("pd_hi_rct", pin_func_d[39:20], {LSG, BIA, PMP, PMP});
        wr(pin_mux_pkg::OFS_DIR_D, 8'h00); chk("out_en_d", pin_out_en_d, 8'h0f);
        $display("test port d done");
        wr(pin_mux_pkg::OFS_SUPPLY, 8'h2a); chk("aux_no_pf0", aux_supply_sel, 3'b000);
        wr(pin_mux_pkg::OFS_PF_LO, 8'h01); chk("aux_all", aux_supply_sel, 3'b111);
        wr(pin_mux_pkg::OFS_SUPPLY, 8'h15); chk("aux_low_bits", aux_supply_sel, 3'b000);
        wr(pin_mux_pkg::OFS_SUPPLY, 8'h08); chk("aux_pb_only", aux_supply_sel, 3'b010);
        wr(pin_mux_pkg::OFS_SUPPLY, 8'h02); chk("aux_pa_only", aux_supply_sel, 3'b001);
        rd(pin_mux_pkg::OFS_STATUS); chk("status_aux", rd_seen, 32'h1);
        rd(pin_mux_pkg::OFS_SUPPLY); chk("supply_read", rd_seen, 32'h02);
        $display("test supply done");
        wr(8'h40, 8'h55); chk("unmapped_wr", resp_seen, pin_mux_pkg::RESP_SLVERR);
        rd(8'h40); chk("unmapped_rd", {resp_seen, rd_seen}, {pin_mux_pkg::RESP_SLVERR, 32'h0});
        $display("test unmapped done");
        print_verdict();
    end
endmodule
